// file: src/cpu_regs_params.svh
// Functional notes
// - Program counter keeps 26 bits; bits 31..26 read zero, carry out of 25 dropped.
// - Program counter bit 0 is always zero.
// - General register zero always reads zero.
// - Short load/store use general register 30 as implicit base pointer.
// - Thirty-two general registers; each general register 32 bits wide.
// - System registers selected by number: 0..5 and 16..20.
// - Exception source (4) readable by store, not writable by load.
// - Debug save registers 18, 19 accessible only inside debug trap window.
// - Return from interrupt forces restored counter bit 0 to zero.
// - Exception or maskable interrupt saves counter and status to interrupt pair.
// - Non-maskable interrupt saves counter and status to the NMI pair.
// - Saved counter is the address of the next instruction.
// - Interrupt saved counter bits 31..26, saved status bits 31..8 read zero.
// - Return from interrupt reloads counter and status from the NMI pair when NP is set and EP clear, else from the interrupt pair.
// - Exception source loaded with the event code on exception, maskable interrupt and NMI entry, not on debug trap entry.
// - Taking an NMI sets the NMI-in-service status flag.
// - Status written by system load takes effect right after that instruction.
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

`define SR_INTR_PC 5'h00
`define SR_INTR_PSW 5'h01
`define SR_NMI_PC 5'h02
`define SR_NMI_PSW 5'h03
`define SR_EXC_SRC 5'h04
`define SR_PSW 5'h05
`define SR_CT_PC 5'h10
`define SR_CT_PSW 5'h11
`define SR_DBG_PC 5'h12
`define SR_DBG_PSW 5'h13
`define SR_CT_BASE 5'h14

`define PC_BITS 26
`define PSW_BITS 8
`define PSW_RESET 8'h20
`define PSW_NP_BIT 7
`define PSW_EP_BIT 6
`define PSW_ID_BIT 5
`define GPR_ZERO 5'h00
`define GPR_ELEM_BASE 5'h1E
`define PC_RESET 26'h0000000

`endif

// file: src/cpu_regs_pkg.sv
package cpu_regs_pkg;
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_INTR = 2'b01,
		EV_NMI = 2'b10,
		EV_DEBUG = 2'b11
	} entry_type;
	typedef logic [31:0] word_type;
endpackage

// file: src/gpr_bank.sv
`timescale 1ns/1ps
`include "cpu_regs_params.svh"
module gpr_bank (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Sync reset
	input wire logic wr_en, // Write strobe
	input wire logic [4:0] wr_idx, // Write register number
	input wire cpu_regs_pkg::word_type wr_data, // Write data
	input wire logic [4:0] rd_a_idx, // Read port A number
	input wire logic [4:0] rd_b_idx, // Read port B number
	output cpu_regs_pkg::word_type rd_a_q, // Port A data
	output cpu_regs_pkg::word_type rd_b_q, // Port B data
	output cpu_regs_pkg::word_type elem_base_q // Register 30
);
	cpu_regs_pkg::word_type regs_q [32];
	cpu_regs_pkg::word_type regs_d [32];
	cpu_regs_pkg::word_type rd_a_d, rd_b_d, elem_base_d;

	function automatic cpu_regs_pkg::word_type fetch(input logic [4:0] idx,
			input cpu_regs_pkg::word_type v);
		fetch = (idx == `GPR_ZERO) ? 32'h00000000 : v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_reg
			always_comb begin
				regs_d[g] = regs_q[g];
				if (wr_en && wr_idx == 5'(g) && g != 0) begin
					regs_d[g] = wr_data;
				end
			end
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					regs_q[g] <= 32'h00000000;
				end else begin
					regs_q[g] <= regs_d[g];
				end
			end
		end
	endgenerate

	always_comb begin
		rd_a_d = fetch(rd_a_idx, regs_d[rd_a_idx]);
		rd_b_d = fetch(rd_b_idx, regs_d[rd_b_idx]);
		elem_base_d = regs_d[`GPR_ELEM_BASE];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_a_q <= 32'h00000000;
			rd_b_q <= 32'h00000000;
			elem_base_q <= 32'h00000000;
		end else begin
			rd_a_q <= rd_a_d;
			rd_b_q <= rd_b_d;
			elem_base_q <= elem_base_d;
		end
	end
endmodule // gpr_bank

// file: src/cpu_register_set.sv
`timescale 1ns/1ps
`include "cpu_regs_params.svh"
module cpu_register_set (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Sync reset, active high
	input wire logic gpr_wr_en, // General register write
	input wire logic [4:0] gpr_wr_idx, // General register write number
	input wire logic [31:0] gpr_wr_data, // General register write data
	input wire logic [4:0] gpr_rd_a_idx, // Read port A number
	input wire logic [4:0] gpr_rd_b_idx, // Read port B number
	output logic [31:0] gpr_rd_a, // Read port A data
	output logic [31:0] gpr_rd_b, // Read port B data
	output logic [31:0] element_base_pointer, // Base for short load/store
	input wire logic pc_load, // Load counter (branch)
	input wire logic [31:0] pc_target, // Branch target
	input wire logic pc_advance, // Step counter
	input wire logic [31:0] pc_step, // Instruction length in bytes
	input wire logic [31:0] pc_next_instr, // Address of following instruction
	output logic [31:0] program_counter, // Counter value
	input wire logic sysreg_load_instr, // System register write
	input wire logic sysreg_store_instr, // System register read
	input wire logic [4:0] sysreg_idx, // System register number
	input wire logic [31:0] sysreg_wr_data, // System register write data
	output logic [31:0] sysreg_rd_data, // System register read data
	output logic sysreg_rd_valid, // Read data valid, one cycle
	input wire logic flags_wr, // Arithmetic flag update
	input wire logic [4:0] flags_in, // New SAT CY OV S Z
	input wire logic exc_take, // Take exception or maskable interrupt
	input wire logic nmi_take, // Take non-maskable interrupt
	input wire logic debug_trap_instr, // Debug trap or illegal opcode
	input wire logic [31:0] exc_code, // Exception code of source
	input wire logic [31:0] handler_addr, // Handler entry address
	input wire logic interrupt_return_instr, // Return from interrupt
	input wire logic debug_return_instr, // Return from debug trap
	output logic [7:0] program_status_word, // Status flags
	output logic nmi_in_service_flag, // NMI being serviced
	output logic debug_window // Debug save registers accessible
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [25:0] pc_q, pc_d;
	logic [7:0] psw_q, psw_d;
	logic [25:0] intr_saved_counter_q, intr_saved_counter_d;
	logic [7:0] intr_saved_status_q, intr_saved_status_d;
	logic [25:0] nmi_saved_counter_q, nmi_saved_counter_d;
	logic [7:0] nmi_saved_status_q, nmi_saved_status_d;
	logic [31:0] ecr_q, ecr_d;
	logic [25:0] table_call_saved_counter_q, table_call_saved_counter_d;
	logic [7:0] table_call_saved_status_q, table_call_saved_status_d;
	logic [25:0] debug_saved_counter_q, debug_saved_counter_d;
	logic [7:0] debug_saved_status_q, debug_saved_status_d;
	logic [31:0] table_call_base_q, table_call_base_d;
	logic dbg_q, dbg_d;
	logic [31:0] rd_q, rd_d;
	logic rdv_q, rdv_d;
	cpu_regs_pkg::entry_type ev;

	function automatic logic [25:0] even_pc(input logic [31:0] v);
		even_pc = {v[25:1], 1'b0};
	endfunction

	function automatic logic [31:0] widen_pc(input logic [25:0] v);
		widen_pc = {6'h00, v};
	endfunction

	function automatic logic [31:0] widen_psw(input logic [7:0] v);
		widen_psw = {24'h000000, v};
	endfunction

	function automatic logic dbg_reg(input logic [4:0] idx);
		dbg_reg = (idx == `SR_DBG_PC) || (idx == `SR_DBG_PSW);
	endfunction

	// ----------------------------------------------------------------
	// General registers
	// ----------------------------------------------------------------
	gpr_bank gpr_bank_i (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(gpr_wr_en),
		.wr_idx(gpr_wr_idx),
		.wr_data(gpr_wr_data),
		.rd_a_idx(gpr_rd_a_idx),
		.rd_b_idx(gpr_rd_b_idx),
		.rd_a_q(gpr_rd_a),
		.rd_b_q(gpr_rd_b),
		.elem_base_q(element_base_pointer)
	);

	// ----------------------------------------------------------------
	// Event priority
	// ----------------------------------------------------------------
	always_comb begin
		if (nmi_take) begin
			ev = cpu_regs_pkg::EV_NMI;
		end else if (exc_take) begin
			ev = cpu_regs_pkg::EV_INTR;
		end else if (debug_trap_instr) begin
			ev = cpu_regs_pkg::EV_DEBUG;
		end else begin
			ev = cpu_regs_pkg::EV_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		pc_d = pc_q;
		psw_d = psw_q;
		intr_saved_counter_d = intr_saved_counter_q;
		intr_saved_status_d = intr_saved_status_q;
		nmi_saved_counter_d = nmi_saved_counter_q;
		nmi_saved_status_d = nmi_saved_status_q;
		table_call_saved_counter_d = table_call_saved_counter_q;
		table_call_saved_status_d = table_call_saved_status_q;
		debug_saved_counter_d = debug_saved_counter_q;
		debug_saved_status_d = debug_saved_status_q;
		table_call_base_d = table_call_base_q;
		if (pc_load) begin
			pc_d = even_pc(pc_target);
		end else if (pc_advance) begin
			pc_d = even_pc({6'h00, pc_q} + pc_step);
		end
		if (flags_wr) begin
			psw_d[4:0] = flags_in;
		end
		if (sysreg_load_instr && !(dbg_reg(sysreg_idx) && !dbg_q)) begin
			unique case (sysreg_idx)
				`SR_INTR_PC: intr_saved_counter_d = sysreg_wr_data[25:0];
				`SR_INTR_PSW: intr_saved_status_d = sysreg_wr_data[7:0];
				`SR_NMI_PC: nmi_saved_counter_d = sysreg_wr_data[25:0];
				`SR_NMI_PSW: nmi_saved_status_d = sysreg_wr_data[7:0];
				`SR_PSW: psw_d = sysreg_wr_data[7:0];
				`SR_CT_PC: table_call_saved_counter_d = sysreg_wr_data[25:0];
				`SR_CT_PSW: table_call_saved_status_d = sysreg_wr_data[7:0];
				`SR_DBG_PC: debug_saved_counter_d = sysreg_wr_data[25:0];
				`SR_DBG_PSW: debug_saved_status_d = sysreg_wr_data[7:0];
				`SR_CT_BASE: table_call_base_d = sysreg_wr_data;
				default: ;
			endcase
		end
		unique case (ev)
			cpu_regs_pkg::EV_NMI: begin
				nmi_saved_counter_d = pc_next_instr[25:0];
				nmi_saved_status_d = psw_q;
				psw_d[`PSW_NP_BIT] = 1'b1;
				psw_d[`PSW_ID_BIT] = 1'b1;
				pc_d = even_pc(handler_addr);
			end
			cpu_regs_pkg::EV_INTR: begin
				intr_saved_counter_d = pc_next_instr[25:0];
				intr_saved_status_d = psw_q;
				psw_d[`PSW_EP_BIT] = 1'b1;
				psw_d[`PSW_ID_BIT] = 1'b1;
				pc_d = even_pc(handler_addr);
			end
			cpu_regs_pkg::EV_DEBUG: begin
				debug_saved_counter_d = pc_next_instr[25:0];
				debug_saved_status_d = psw_q;
				psw_d[`PSW_NP_BIT] = 1'b1;
				psw_d[`PSW_EP_BIT] = 1'b1;
				psw_d[`PSW_ID_BIT] = 1'b1;
				pc_d = even_pc(handler_addr);
			end
			cpu_regs_pkg::EV_NONE: begin
				if (interrupt_return_instr) begin
					if (psw_q[`PSW_NP_BIT] && !psw_q[`PSW_EP_BIT]) begin
						pc_d = {nmi_saved_counter_q[25:1], 1'b0};
						psw_d = nmi_saved_status_q;
					end else begin
						pc_d = {intr_saved_counter_q[25:1], 1'b0};
						psw_d = intr_saved_status_q;
					end
				end else if (debug_return_instr && dbg_q) begin
					pc_d = {debug_saved_counter_q[25:1], 1'b0};
					psw_d = debug_saved_status_q;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_q <= `PC_RESET;
			psw_q <= `PSW_RESET;
			intr_saved_counter_q <= 26'h0000000;
			intr_saved_status_q <= 8'h00;
			nmi_saved_counter_q <= 26'h0000000;
			nmi_saved_status_q <= 8'h00;
			table_call_saved_counter_q <= 26'h0000000;
			table_call_saved_status_q <= 8'h00;
			debug_saved_counter_q <= 26'h0000000;
			debug_saved_status_q <= 8'h00;
			table_call_base_q <= 32'h00000000;
		end else begin
			pc_q <= pc_d;
			psw_q <= psw_d;
			intr_saved_counter_q <= intr_saved_counter_d;
			intr_saved_status_q <= intr_saved_status_d;
			nmi_saved_counter_q <= nmi_saved_counter_d;
			nmi_saved_status_q <= nmi_saved_status_d;
			table_call_saved_counter_q <= table_call_saved_counter_d;
			table_call_saved_status_q <= table_call_saved_status_d;
			debug_saved_counter_q <= debug_saved_counter_d;
			debug_saved_status_q <= debug_saved_status_d;
			table_call_base_q <= table_call_base_d;
		end
	end

	// ----------------------------------------------------------------
	// Exception source
	// ----------------------------------------------------------------
	always_comb begin
		ecr_d = ecr_q;
		unique case (ev)
			cpu_regs_pkg::EV_NMI, cpu_regs_pkg::EV_INTR: begin
				ecr_d = exc_code;
			end
			cpu_regs_pkg::EV_DEBUG, cpu_regs_pkg::EV_NONE: begin
				// Debug trap leaves the recorded source untouched
				ecr_d = ecr_q;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ecr_q <= 32'h00000000;
		end else begin
			ecr_q <= ecr_d;
		end
	end

	// ----------------------------------------------------------------
	// Debug window
	// ----------------------------------------------------------------
	always_comb begin
		dbg_d = dbg_q;
		unique case (ev)
			cpu_regs_pkg::EV_DEBUG: begin
				dbg_d = 1'b1;
			end
			cpu_regs_pkg::EV_NONE: begin
				// Return from interrupt wins over debug return
				if (!interrupt_return_instr && debug_return_instr) begin
					dbg_d = 1'b0;
				end
			end
			cpu_regs_pkg::EV_NMI, cpu_regs_pkg::EV_INTR: begin
				dbg_d = dbg_q;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dbg_q <= 1'b0;
		end else begin
			dbg_q <= dbg_d;
		end
	end

	// ----------------------------------------------------------------
	// System register read port
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = 32'h00000000;
		rdv_d = 1'b0;
		if (sysreg_store_instr) begin
			rdv_d = 1'b1;
			// Closed debug window and reserved numbers read as zero
			if (!(dbg_reg(sysreg_idx) && !dbg_q)) begin
				unique case (sysreg_idx)
					`SR_INTR_PC: rd_d = widen_pc(intr_saved_counter_q);
					`SR_INTR_PSW: rd_d = widen_psw(intr_saved_status_q);
					`SR_NMI_PC: rd_d = widen_pc(nmi_saved_counter_q);
					`SR_NMI_PSW: rd_d = widen_psw(nmi_saved_status_q);
					`SR_EXC_SRC: rd_d = ecr_q;
					`SR_PSW: rd_d = widen_psw(psw_q);
					`SR_CT_PC: rd_d = widen_pc(table_call_saved_counter_q);
					`SR_CT_PSW: rd_d = widen_psw(table_call_saved_status_q);
					`SR_DBG_PC: rd_d = widen_pc(debug_saved_counter_q);
					`SR_DBG_PSW: rd_d = widen_psw(debug_saved_status_q);
					`SR_CT_BASE: rd_d = table_call_base_q;
					default: rd_d = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_q <= 32'h00000000;
			rdv_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			rdv_q <= rdv_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign program_counter = {6'h00, pc_q};
	assign program_status_word = psw_q;
	assign nmi_in_service_flag = psw_q[`PSW_NP_BIT];
	assign debug_window = dbg_q;
	assign sysreg_rd_data = rd_q;
	assign sysreg_rd_valid = rdv_q;
endmodule // cpu_register_set

// file: bench/cpu_register_set_monitor.sv
`timescale 1ns/1ps
module cpu_register_set_monitor (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Sync reset
	input wire logic gpr_wr_en, // Gpr write
	input wire logic [4:0] gpr_wr_idx, // Gpr write number
	input wire logic [31:0] gpr_wr_data, // Gpr write data
	input wire logic [4:0] gpr_rd_a_idx, // Port A number
	input wire logic [31:0] gpr_rd_a, // Port A data
	input wire logic [31:0] element_base_pointer, // Register 30 copy
	input wire logic [31:0] pc_next_instr, // Next address
	input wire logic [31:0] program_counter, // Counter
	input wire logic sysreg_load_instr, // Sysreg write
	input wire logic sysreg_store_instr, // Sysreg read
	input wire logic [4:0] sysreg_idx, // Sysreg number
	input wire logic [31:0] sysreg_wr_data, // Sysreg write data
	input wire logic [31:0] sysreg_rd_data, // Sysreg read data
	input wire logic sysreg_rd_valid, // Read valid
	input wire logic flags_wr, // Flag update
	input wire logic exc_take, // Exception entry
	input wire logic nmi_take, // NMI entry
	input wire logic debug_trap_instr, // Debug entry
	input wire logic interrupt_return_instr, // Interrupt return
	input wire logic debug_return_instr, // Debug return
	input wire logic [7:0] program_status_word, // Status
	input wire logic nmi_in_service_flag // NMI in service
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Entry and return steps
	// ----------------------------------------
	sequence s_exc_entry;
		exc_take && !nmi_take && !sysreg_load_instr;
	endsequence
	sequence s_intr_return;
		interrupt_return_instr && !exc_take && !nmi_take && !debug_trap_instr
			&& !debug_return_instr && !flags_wr && !sysreg_load_instr;
	endsequence
	a_pc_high_zero: assert property (program_counter[31:26] == 6'h00)
		else $error("counter high bits set");
	a_pc_bit0_zero: assert property (program_counter[0] == 1'b0)
		else $error("counter bit 0 set");
	a_gpr_zero_read: assert property (gpr_rd_a_idx == 5'h00 |=> gpr_rd_a == 32'h00000000)
		else $error("register zero not zero");
	a_elem_base_follow: assert property (gpr_wr_en && gpr_wr_idx == 5'h1E
		|=> element_base_pointer == $past(gpr_wr_data)) else $error("base pointer stale");
	a_reserved_reads_zero: assert property (sysreg_store_instr
		&& ((sysreg_idx >= 5'h06 && sysreg_idx <= 5'h0F) || sysreg_idx >= 5'h15)
		|=> sysreg_rd_valid && sysreg_rd_data == 32'h00000000) else $error("reserved read");
	a_read_valid_once: assert property (!$past(sys_rst)
		|-> sysreg_rd_valid == $past(sysreg_store_instr)) else $error("read valid wrong");
	a_nmi_flag_set: assert property (nmi_take
		|=> nmi_in_service_flag && program_status_word[7]) else $error("nmi flag clear");
	a_psw_load_now: assert property (sysreg_load_instr && sysreg_idx == 5'h05
		&& sysreg_wr_data[31:8] == 24'h000000 && !exc_take && !nmi_take && !debug_trap_instr
		&& !interrupt_return_instr && !debug_return_instr && !flags_wr
		|=> {24'h000000, program_status_word} == $past(sysreg_wr_data))
		else $error("status load late");
	a_intr_round_trip: assert property (s_exc_entry ##1 s_intr_return
		|=> program_counter == ($past(pc_next_instr, 2) & 32'h03FFFFFE)
		&& program_status_word == $past(program_status_word, 2)) else $error("return wrong");
endmodule // cpu_register_set_monitor

bind cpu_register_set cpu_register_set_monitor cpu_register_set_monitor_i (.clk, .sys_rst,
	.gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .gpr_rd_a_idx, .gpr_rd_a, .element_base_pointer,
	.pc_next_instr, .program_counter, .sysreg_load_instr, .sysreg_store_instr, .sysreg_idx,
	.sysreg_wr_data, .sysreg_rd_data, .sysreg_rd_valid, .flags_wr, .exc_take, .nmi_take,
	.debug_trap_instr, .interrupt_return_instr, .debug_return_instr, .program_status_word,
	.nmi_in_service_flag);

// file: bench/cpu_register_set_test.sv
`timescale 1ns/1ps
module cpu_register_set_test;
	logic clk, sys_rst, gpr_wr_en, pc_load, pc_advance, sysreg_load_instr, sysreg_store_instr;
	logic flags_wr, exc_take, nmi_take, debug_trap_instr, interrupt_return_instr;
	logic debug_return_instr, sysreg_rd_valid, nmi_in_service_flag, debug_window;
	logic [4:0] gpr_wr_idx, gpr_rd_a_idx, gpr_rd_b_idx, sysreg_idx, flags_in;
	logic [31:0] gpr_wr_data, gpr_rd_a, gpr_rd_b, element_base_pointer, pc_target, pc_step;
	logic [31:0] pc_next_instr, program_counter, sysreg_wr_data, sysreg_rd_data, rd;
	logic [31:0] exc_code, handler_addr;
	logic [7:0] program_status_word;
	int failures = 0;
	int checks = 0;
	logic [4:0] tid [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h14, 5'h04, 5'h09,
		5'h19, 5'h12};
	logic [31:0] twr [11] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'h0000ABCD, 32'h00000011, 32'h00001234, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'hFFFFFFFF};
	logic [31:0] texp [11] = '{32'h03FFFFFF, 32'h000000FF, 32'h03FFFFFF, 32'h000000FF,
		32'h0000ABCD, 32'h00000011, 32'h00001234, 32'h0, 32'h0, 32'h0, 32'h0};
	cpu_register_set cpu_register_set_i (.clk, .sys_rst, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data,
		.gpr_rd_a_idx, .gpr_rd_b_idx, .gpr_rd_a, .gpr_rd_b, .element_base_pointer, .pc_load,
		.pc_target, .pc_advance, .pc_step, .pc_next_instr, .program_counter, .sysreg_load_instr,
		.sysreg_store_instr, .sysreg_idx, .sysreg_wr_data, .sysreg_rd_data, .sysreg_rd_valid,
		.flags_wr, .flags_in, .exc_take, .nmi_take, .debug_trap_instr, .exc_code, .handler_addr,
		.interrupt_return_instr, .debug_return_instr, .program_status_word,
		.nmi_in_service_flag, .debug_window);
	always #2 clk = ~clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		if (failures == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task sr_wr(input logic [4:0] i, input logic [31:0] d);
		@(posedge clk);
		sysreg_load_instr <= 1'b1;
		sysreg_idx <= i;
		sysreg_wr_data <= d;
		@(posedge clk);
		sysreg_load_instr <= 1'b0;
		#1;
	endtask
	task sr_rd(input logic [4:0] i, output logic [31:0] d);
		@(posedge clk);
		sysreg_store_instr <= 1'b1;
		sysreg_idx <= i;
		@(posedge clk);
		sysreg_store_instr <= 1'b0;
		#1 d = sysreg_rd_data;
	endtask
	// Mask bits: debug return, debug trap, interrupt return, nmi, exception
	task fire(input logic [4:0] m1, input logic [4:0] m2);
		@(posedge clk);
		{debug_return_instr, debug_trap_instr, interrupt_return_instr, nmi_take, exc_take} <= m1;
		@(posedge clk);
		{debug_return_instr, debug_trap_instr, interrupt_return_instr, nmi_take, exc_take} <= m2;
		if (m2 != 5'h00) begin
			@(posedge clk);
			{debug_return_instr, debug_trap_instr, interrupt_return_instr, nmi_take, exc_take}
				<= 5'h00;
		end
		#1;
	endtask
	task t_gpr;
		@(posedge clk);
		gpr_wr_en <= 1'b1;
		gpr_wr_data <= 32'hFFFFFFFF;
		@(posedge clk);
		gpr_wr_idx <= 5'h1E;
		gpr_wr_data <= 32'hA5A5A5A5;
		@(posedge clk);
		gpr_wr_idx <= 5'h1F;
		gpr_wr_data <= 32'h12345678;
		#1 chk(element_base_pointer, 32'hA5A5A5A5);
		@(posedge clk);
		gpr_wr_en <= 1'b0;
		gpr_rd_b_idx <= 5'h1F;
		@(posedge clk);
		#1 chk(gpr_rd_a, 32'h00000000);
		chk(gpr_rd_b, 32'h12345678);
	endtask
	task t_pc;
		@(posedge clk);
		pc_load <= 1'b1;
		pc_target <= 32'hFFFFFFFF;
		@(posedge clk);
		pc_load <= 1'b0;
		pc_advance <= 1'b1;
		pc_step <= 32'h00000004;
		#1 chk(program_counter, 32'h03FFFFFE);
		@(posedge clk);
		pc_advance <= 1'b0;
		#1 chk(program_counter, 32'h00000002);
	endtask
	task t_table;
		for (int k = 0; k < 11; k++) begin
			sr_wr(tid[k], twr[k]);
			sr_rd(tid[k], rd);
			chk(rd, texp[k]);
		end
	endtask
	task t_exc;
		sr_wr(5'h05, 32'h00000005);
		chk({24'h000000, program_status_word}, 32'h00000005);
		@(posedge clk);
		exc_code <= 32'h00000040;
		pc_next_instr <= 32'h0C123457;
		handler_addr <= 32'h00000101;
		fire(5'h01, 5'h04);
		chk(program_counter, 32'h00123456);
		chk({24'h000000, program_status_word}, 32'h00000005);
		sr_rd(5'h00, rd);
		chk(rd, 32'h00123457);
		sr_rd(5'h01, rd);
		chk(rd, 32'h00000005);
		sr_rd(5'h04, rd);
		chk(rd, 32'h00000040);
	endtask
	task t_nmi;
		@(posedge clk);
		pc_next_instr <= 32'h00000201;
		fire(5'h02, 5'h00);
		chk({31'h0, nmi_in_service_flag}, 32'h00000001);
		sr_rd(5'h02, rd);
		chk(rd, 32'h00000201);
		sr_rd(5'h03, rd);
		chk(rd, 32'h00000005);
		sr_rd(5'h00, rd);
		chk(rd, 32'h00123457);
		fire(5'h04, 5'h00);
		chk(program_counter, 32'h00000200);
		chk({24'h000000, program_status_word}, 32'h00000005);
	endtask
	task t_debug;
		fire(5'h08, 5'h00);
		chk({31'h0, debug_window}, 32'h00000001);
		sr_wr(5'h12, 32'h00000ABC);
		sr_rd(5'h12, rd);
		chk(rd, 32'h00000ABC);
		fire(5'h10, 5'h00);
		chk({31'h0, debug_window}, 32'h00000000);
		chk(program_counter, 32'h00000ABC);
		sr_rd(5'h12, rd);
		chk(rd, 32'h00000000);
	endtask
	task t_flags;
		@(posedge clk);
		sysreg_load_instr <= 1'b1;
		sysreg_idx <= 5'h05;
		sysreg_wr_data <= 32'h000000E0;
		flags_wr <= 1'b1;
		flags_in <= 5'h13;
		@(posedge clk);
		sysreg_load_instr <= 1'b0;
		#1 chk({24'h000000, program_status_word}, 32'h000000E0);
		@(posedge clk);
		flags_wr <= 1'b0;
		#1 chk({24'h000000, program_status_word}, 32'h000000F3);
	endtask
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{gpr_wr_en, pc_load, pc_advance, sysreg_load_instr, sysreg_store_instr, flags_wr} = '0;
		{exc_take, nmi_take, debug_trap_instr, interrupt_return_instr, debug_return_instr} = '0;
		{gpr_wr_idx, gpr_rd_a_idx, gpr_rd_b_idx, sysreg_idx, flags_in} = '0;
		{gpr_wr_data, pc_target, pc_step, pc_next_instr, sysreg_wr_data} = '0;
		{exc_code, handler_addr} = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk(program_counter, 32'h00000000);
		chk({24'h000000, program_status_word}, 32'h00000020);
		t_gpr();
		t_pc();
		t_table();
		t_exc();
		t_nmi();
		t_debug();
		t_flags();
		tally_and_finish();
	end
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule // cpu_register_set_test
